// ### rtl/gedft_pkg.sv
package gedft_pkg;
  // Clock rate
  localparam int CLK_HZ = 25000000;
  localparam int CLK_NS = 40;
  // Start-up and quick reset
  localparam int STARTUP_MS = 10;
  localparam int STARTUP_CYC = STARTUP_MS * (CLK_HZ / 1000);
  localparam int QUICK_US = 10;
  localparam int QUICK_CYC = (QUICK_US * 1000) / CLK_NS;
  // Error response
  localparam int ERR_NS = 200;
  localparam int ERR_CYC = ERR_NS / CLK_NS;
  // Dead time range
  localparam int DT_MIN_NS = 50;
  localparam int DT_MAX_NS = 500;
  localparam int DT_MIN_CYC = (DT_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int DT_MAX_CYC = (DT_MAX_NS + CLK_NS - 1) / CLK_NS;
  localparam int DT_W = 4;
  // Handshake minimum gap
  localparam int HS_NS = 50;
  localparam int HS_CYC = (HS_NS + CLK_NS - 1) / CLK_NS;
  // Minimum passed on-pulse
  localparam int ON_MIN_NS = 50;
  localparam int ON_MIN_CYC = (ON_MIN_NS + CLK_NS - 1) / CLK_NS;
  // Serial word
  localparam int SER_W = 16;
  localparam logic [15:0] SER_RST = 16'h0000;

  typedef enum logic [1:0] {
    GEDFT_OFF = 2'b00,
    GEDFT_START = 2'b01,
    GEDFT_RUN = 2'b11,
    GEDFT_QUICK = 2'b10
  } gedft_state_t;
endpackage : gedft_pkg

// ### rtl/gedft_phase.sv
`timescale 1ns/10ps
// One half-bridge: dead time as a minimum gap, forced low on block.
module gedft_phase #(
  parameter int DT_W = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic block,
  input wire logic [DT_W-1:0] dt_cyc,
  // Commands
  input wire logic want_hi,
  input wire logic want_lo,
  // Gates
  output logic gate_hi,
  output logic gate_lo
);
  logic gate_hi_r;
  logic gate_lo_r;
  logic [DT_W-1:0] gap_r;
  logic [DT_W-1:0] gap_nxt;
  logic hi_nxt;
  logic lo_nxt;
  wire both_off = !gate_hi_r && !gate_lo_r;
  wire gap_done = (gap_r >= dt_cyc);
  wire conflict = want_hi && want_lo;
  if (DT_W < 2) begin : gen_bad_width
    $error("gedft_phase: dead time width too small");
  end
  // Gap counts from the handshake point, so host dead time already counts toward it
  assign gap_nxt = (!both_off) ? '0 : (gap_done ? gap_r : gap_r + 1'b1);
  assign hi_nxt = !block && !conflict && want_hi && (gate_hi_r || (both_off && gap_done));
  assign lo_nxt = !block && !conflict && want_lo && (gate_lo_r || (both_off && gap_done));
  always_ff @(posedge clk) begin
    if (rst) begin
      gate_hi_r <= 1'b0;
      gate_lo_r <= 1'b0;
      gap_r <= '0;
    end else begin
      gate_hi_r <= hi_nxt;
      gate_lo_r <= lo_nxt;
      gap_r <= gap_nxt;
    end
  end
  assign gate_hi = gate_hi_r;
  assign gate_lo = gate_lo_r;
endmodule : gedft_phase

// ### rtl/gedft_top.sv
`timescale 1ns/10ps
module gedft_top #(
  parameter int STARTUP_CYC = gedft_pkg::STARTUP_CYC,
  parameter int PHASES = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Enable and error sources
  input wire logic gate_enable,
  input wire logic error_event,
  // Dead time setting from resistor, in clock cycles
  input wire logic [gedft_pkg::DT_W-1:0] deadtime_set_resistor,
  // PWM inputs
  input wire logic [PHASES-1:0] pwm_high_in,
  input wire logic [PHASES-1:0] pwm_low_in,
  // Gate outputs
  output logic [PHASES-1:0] high_side_gate_out,
  output logic [PHASES-1:0] low_side_gate_out,
  // Status
  output logic fault_n,
  output logic ready,
  // Serial slave
  input wire logic serial_clk,
  input wire logic serial_select_n,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_oe,
  // Received word and word to send
  input wire logic [gedft_pkg::SER_W-1:0] tx_word,
  output logic [gedft_pkg::SER_W-1:0] rx_word,
  output logic rx_valid
);
  localparam int SW = gedft_pkg::SER_W;
  localparam int CNT_W = $clog2(STARTUP_CYC + 1);
  localparam int QW = $clog2(gedft_pkg::QUICK_CYC + 2);
  localparam int EW = 4;
  localparam int DTW = gedft_pkg::DT_W;

  // Dead time ceiling must fit the setting port, error delay needs two sync stages
  if (PHASES < 1 || STARTUP_CYC < 1 || gedft_pkg::ERR_CYC < 2 ||
      gedft_pkg::DT_MAX_CYC >= (1 << DTW)) begin : gen_bad_param
    $error("gedft_top: bad parameter");
  end

  // Synchronisers for the enable, error, serial, PWM and dead time inputs
  logic [1:0] en_s, err_s, sck_s, cs_s, sdi_s;
  logic [PHASES-1:0] ph1, ph2, pl1, pl2;
  logic [DTW-1:0] dt1, dt2;
  logic sck_d_r;
  always_ff @(posedge clk) begin
    en_s <= {en_s[0], gate_enable};
    err_s <= {err_s[0], error_event};
    sck_s <= {sck_s[0], serial_clk};
    cs_s <= {cs_s[0], serial_select_n};
    sdi_s <= {sdi_s[0], serial_in};
    ph1 <= pwm_high_in;
    ph2 <= ph1;
    pl1 <= pwm_low_in;
    pl2 <= pl1;
    dt1 <= deadtime_set_resistor;
    dt2 <= dt1;
    sck_d_r <= sck_s[1];
  end
  wire en = en_s[1];
  wire err = err_s[1];
  wire cs_act = !cs_s[1];
  wire sck_rise = sck_s[1] && !sck_d_r;
  wire sck_fall = !sck_s[1] && sck_d_r;

  // Dead time clamped to its documented range
  localparam logic [DTW-1:0] DT_LO = DTW'(gedft_pkg::DT_MIN_CYC);
  localparam logic [DTW-1:0] DT_HI = DTW'(gedft_pkg::DT_MAX_CYC);
  wire [DTW-1:0] dt_use = (dt2 < DT_LO) ? DT_LO : ((dt2 > DT_HI) ? DT_HI : dt2);

  // Enable sequencing
  gedft_pkg::gedft_state_t st_r, st_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [QW-1:0] qcnt_r, qcnt_nxt;
  logic fault_r, fault_nxt;
  logic ready_r, fault_n_r;
  logic [EW-1:0] ecnt_r, ecnt_nxt;
  wire start_done = (cnt_r == CNT_W'(STARTUP_CYC - 1));
  wire quick_over = (qcnt_r >= QW'(gedft_pkg::QUICK_CYC));
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    qcnt_nxt = '0;
    case (st_r)
      gedft_pkg::GEDFT_OFF: begin
        cnt_nxt = '0;
        if (en) st_nxt = gedft_pkg::GEDFT_START;
      end
      gedft_pkg::GEDFT_START: begin
        if (!en) st_nxt = gedft_pkg::GEDFT_OFF;
        else if (start_done) st_nxt = gedft_pkg::GEDFT_RUN;
        else cnt_nxt = cnt_r + 1'b1;
      end
      gedft_pkg::GEDFT_RUN: begin
        if (!en) st_nxt = gedft_pkg::GEDFT_QUICK;
      end
      gedft_pkg::GEDFT_QUICK: begin
        qcnt_nxt = qcnt_r + 1'b1;
        if (en) st_nxt = gedft_pkg::GEDFT_RUN;
        else if (quick_over) st_nxt = gedft_pkg::GEDFT_OFF;
      end
      default: st_nxt = gedft_pkg::GEDFT_OFF;
    endcase
  end
  wire running = (st_r == gedft_pkg::GEDFT_RUN);
  wire run_nxt = (st_nxt == gedft_pkg::GEDFT_RUN);
  wire clear_faults = (st_r != gedft_pkg::GEDFT_RUN) && (st_nxt == gedft_pkg::GEDFT_RUN);

  // Error delay: the response lands about 200 ns after the event
  wire err_hit = (ecnt_r == EW'(gedft_pkg::ERR_CYC - 2));
  always_comb begin
    ecnt_nxt = '0;
    fault_nxt = fault_r;
    if (clear_faults) fault_nxt = 1'b0;
    if (err && !fault_r) begin
      ecnt_nxt = err_hit ? ecnt_r : ecnt_r + 1'b1;
      if (err_hit) fault_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= gedft_pkg::GEDFT_OFF;
      cnt_r <= '0;
      qcnt_r <= '0;
      fault_r <= 1'b0;
      ecnt_r <= '0;
      ready_r <= 1'b0;
      fault_n_r <= 1'b1;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      qcnt_r <= qcnt_nxt;
      fault_r <= fault_nxt;
      ecnt_r <= ecnt_nxt;
      ready_r <= run_nxt;
      fault_n_r <= !fault_nxt;
    end
  end

  wire block = !running || fault_r || (err && err_hit);

  // Half-bridges
  logic [PHASES-1:0] gh_w, gl_w;
  genvar g;
  generate
    for (g = 0; g < PHASES; g++) begin : gen_ph
      gedft_phase #(.DT_W(DTW)) u_ph (
        .clk(clk),
        .rst(rst),
        .block(block),
        .dt_cyc(dt_use),
        .want_hi(ph2[g]),
        .want_lo(pl2[g]),
        .gate_hi(gh_w[g]),
        .gate_lo(gl_w[g])
      );
    end
  endgenerate

  // Serial slave, mode: sample on falling, launch on rising
  logic [SW-1:0] sh_in_r, sh_out_r;
  logic [$clog2(SW+1)-1:0] bit_r;
  logic sdo_r, oe_r, rxv_r, cs_d_r;
  logic [SW-1:0] rx_r;
  wire cs_fall = cs_act && !cs_d_r;
  wire word_done = (bit_r == ($clog2(SW+1))'(SW - 1)) && sck_fall;
  always_ff @(posedge clk) begin
    if (rst) begin
      sh_in_r <= '0;
      sh_out_r <= gedft_pkg::SER_RST;
      bit_r <= '0;
      sdo_r <= 1'b0;
      oe_r <= 1'b0;
      rxv_r <= 1'b0;
      rx_r <= gedft_pkg::SER_RST;
      cs_d_r <= 1'b0;
    end else begin
      cs_d_r <= cs_act;
      rxv_r <= 1'b0;
      oe_r <= cs_act;
      if (!cs_act) begin
        bit_r <= '0;
      end else if (cs_fall) begin
        // First rising edge relaunches the top bit so every fall sees its own bit
        sh_out_r <= tx_word;
        sdo_r <= tx_word[SW-1];
        bit_r <= '0;
      end else begin
        if (sck_rise) begin
          sdo_r <= sh_out_r[SW-1];
          sh_out_r <= {sh_out_r[SW-2:0], 1'b0};
        end
        if (sck_fall) begin
          sh_in_r <= {sh_in_r[SW-2:0], sdi_s[1]};
          bit_r <= word_done ? '0 : bit_r + 1'b1;
          if (word_done) begin
            rx_r <= {sh_in_r[SW-2:0], sdi_s[1]};
            rxv_r <= 1'b1;
          end
        end
      end
    end
  end

  assign high_side_gate_out = gh_w;
  assign low_side_gate_out = gl_w;
  assign fault_n = fault_n_r;
  assign ready = ready_r;
  assign serial_out = sdo_r;
  assign serial_out_oe = oe_r;
  assign rx_word = rx_r;
  assign rx_valid = rxv_r;
endmodule : gedft_top

// ### testbench/gedft_props.sv
`timescale 1ns/10ps
module gedft_props #(
  parameter int PHASES = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Watched pins
  input wire logic gate_enable,
  input wire logic error_event,
  input wire logic [PHASES-1:0] high_side_gate_out,
  input wire logic [PHASES-1:0] low_side_gate_out,
  input wire logic fault_n,
  input wire logic ready,
  input wire logic serial_select_n,
  input wire logic serial_out_oe
);
  wire logic [PHASES-1:0] g = high_side_gate_out | low_side_gate_out;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Slack of a few cycles covers the enable synchroniser
  a_off_gates_low: assert property (!gate_enable [*6] |-> g == '0)
    else $error("gate on while disabled");
  a_no_shoot: assert property ((high_side_gate_out & low_side_gate_out) == '0)
    else $error("both gates on");
  a_gap_hi: assert property ($fell(low_side_gate_out[0]) |-> !high_side_gate_out[0] [*2])
    else $error("high gate too soon");
  a_gap_lo: assert property ($fell(high_side_gate_out[0]) |-> !low_side_gate_out[0] [*2])
    else $error("low gate too soon");
  a_err_gates: assert property ($rose(error_event) |-> ##[1:6] g == '0)
    else $error("gates not cut");
  a_err_fault: assert property ($rose(error_event) && ready |-> ##[1:6] !fault_n)
    else $error("fault not shown");
  a_oe_off: assert property (serial_select_n [*5] |-> !serial_out_oe)
    else $error("output driven unselected");
  a_oe_on: assert property ((ready && !serial_select_n) [*5] |-> serial_out_oe)
    else $error("output not driven");
  c_fault: cover property ($fell(fault_n));
  c_ready: cover property ($rose(ready));
  c_select: cover property ($fell(serial_select_n));
endmodule : gedft_props

bind gedft_top gedft_props #(.PHASES(PHASES)) u_props (
  .clk(clk),
  .rst(rst),
  .gate_enable(gate_enable),
  .error_event(error_event),
  .high_side_gate_out(high_side_gate_out),
  .low_side_gate_out(low_side_gate_out),
  .fault_n(fault_n),
  .ready(ready),
  .serial_select_n(serial_select_n),
  .serial_out_oe(serial_out_oe)
);

// ### testbench/gedft_host.sv
`timescale 1ns/10ps
module gedft_host (
  // Link pins
  output logic serial_clk,
  output logic serial_select_n,
  output logic serial_in,
  input wire logic serial_out
);
  initial begin
    serial_clk = 1'b0;
    serial_select_n = 1'b1;
    serial_in = 1'b0;
  end
  // Master only, clock idles low, MSB first, 320 ns period
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    #7 serial_select_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      #160 serial_clk = 1'b1;
      // Data moves on the rise so it stands still across the sampling fall
      serial_in = tx[i];
      #160 serial_clk = 1'b0;
      rx[i] = serial_out;
    end
    #160 serial_select_n = 1'b1;
    // Released data line must not keep its last value
    serial_in = ~serial_in;
    #320;
  endtask : xfer
endmodule : gedft_host

// ### testbench/gedft_top_tb_top.sv
`timescale 1ns/10ps
module gedft_top_tb_top;
  localparam int SU = 50;
  logic clk, rst, en, err, sclk, ss_n, sin, sout, soe, rxv, fault_n, ready;
  logic [3:0] dt;
  logic [2:0] ph, pl, gh, gl;
  logic [15:0] txw, rxw, got;
  int failures = 0;
  int n_compared = 0;
  int cyc = 0;
  int n_rx = 0;
  gedft_top #(.STARTUP_CYC(SU)) dut (
    .clk(clk), .rst(rst), .gate_enable(en), .error_event(err),
    .deadtime_set_resistor(dt), .pwm_high_in(ph), .pwm_low_in(pl),
    .high_side_gate_out(gh), .low_side_gate_out(gl), .fault_n(fault_n),
    .ready(ready), .serial_clk(sclk), .serial_select_n(ss_n), .serial_in(sin),
    .serial_out(sout), .serial_out_oe(soe), .tx_word(txw), .rx_word(rxw),
    .rx_valid(rxv)
  );
  gedft_host host (.serial_clk(sclk), .serial_select_n(ss_n), .serial_in(sin),
    .serial_out(sout));
  task automatic print_verdict();
    if (failures == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [15:0] a, input logic [15:0] e);
    n_compared++;
    if (a !== e) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e);
    end
  endtask : chk
  task automatic chkb(input logic a, input logic e);
    chk({15'h0, a}, {15'h0, e});
  endtask : chkb
  // Receive strobe stands one cycle; counted away from the launching edge
  always @(negedge clk) begin
    if (rxv === 1'b1) n_rx++;
  end
  task automatic t_start(input int lo);
    int n;
    en = 1'b1;
    n = 0;
    while (ready !== 1'b1 && n < SU + 20) begin
      @(negedge clk);
      n++;
    end
    chkb(n >= lo && n <= lo + 6, 1'b1);
  endtask : t_start
  task automatic t_dead(input logic [3:0] d, input int e);
    int n;
    dt = d;
    ph = 3'h1;
    pl = 3'h0;
    repeat (20) @(negedge clk);
    ph = 3'h0;
    pl = 3'h1;
    n = 0;
    while (gh[0] !== 1'b0 && n < 30) begin
      @(negedge clk);
      n++;
    end
    n = 0;
    while (gl[0] !== 1'b1 && n < 30) begin
      @(negedge clk);
      n++;
    end
    chkb(n >= e && n <= e + 1, 1'b1);
    pl = 3'h0;
    repeat (20) @(negedge clk);
    ph = 3'h1;
    n = 0;
    while (gh[0] !== 1'b1 && n < 30) begin
      @(negedge clk);
      n++;
    end
    chkb(n <= 5, 1'b1);
    ph = 3'h0;
    repeat (20) @(negedge clk);
    ph = 3'h1;
    repeat (2) @(negedge clk);
    ph = 3'h0;
    n = 0;
    repeat (12) begin
      @(negedge clk);
      n += int'(gh[0]);
    end
    chkb(n >= 2 && n <= 3, 1'b1);
  endtask : t_dead
  task automatic t_err();
    int n;
    ph = 3'h1;
    repeat (10) @(negedge clk);
    err = 1'b1;
    n = 0;
    while (fault_n !== 1'b0 && n < 20) begin
      @(negedge clk);
      n++;
    end
    chkb(n <= 6, 1'b1);
    chk({10'h0, gh, gl}, 16'h0000);
    err = 1'b0;
    en = 1'b0;
    repeat (100) @(negedge clk);
    en = 1'b1;
    repeat (20) @(negedge clk);
    chkb(ready, 1'b1);
    chkb(fault_n, 1'b1);
    en = 1'b0;
    repeat (300) @(negedge clk);
    en = 1'b1;
    repeat (20) @(negedge clk);
    chkb(ready, 1'b0);
    t_start(SU - 20);
  endtask : t_err
  task automatic t_ser(input logic [15:0] a, input logic [15:0] b);
    int k;
    @(negedge clk);
    k = n_rx;
    txw = a;
    host.xfer(b, got);
    chk(got, a);
    chk(rxw, b);
    chk(16'(n_rx - k), 16'h0001);
    chkb(soe, 1'b0);
  endtask : t_ser
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Guards against a hung wait loop
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      print_verdict();
    end
  end
  initial begin
    {rst, en, err, dt, ph, pl, txw} = {1'b1, 1'b0, 1'b0, 4'h5, 3'h0, 3'h0, 16'h0000};
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    t_start(SU);
    t_dead(4'h0, 2);
    t_dead(4'hD, 13);
    t_err();
    t_ser(16'hA5C3, 16'h3C96);
    t_ser(16'h5A0F, 16'h8001);
    print_verdict();
  end
endmodule : gedft_top_tb_top
